/* hw/mba_arbiter.sv */
// distributed arbiter for the shared multiprocessor external bus
// Operation
// - drive only the request line selected by the id pins; watch all others.
// - on deadlock the host asserts back-off; master drops bus mid-transaction.
// - assert the lock indicator while the current master has the bus locked.
// - on host request, master yields after its transaction and asserts grant.
// - yielding to host floats bus outputs and puts sdram into self-refresh.
// - master holds host grant until the host drops request; slaves only watch.
// - drive core priority line throughout any core-started external access.
// - drive dma priority line during high-priority dma external access when no core access is pending.
// - every arbiter evaluates the shared lines identically each cycle.
// - id zero is master after reset; priority rotates upward from master.
// - rank host, then core access, then dma access, then plain request.
// - a non-requesting master yields to any other request or the host.
// - requesting master yields to a higher-ranked priority access request.
// - requesting master still yields to a host request.
// - master yields when its tenure count expires and another processor requests.
// - request held while master; master drops request after its transaction.
// - a relinquishing master takes lowest priority; losers keep requesting.
// - outgoing master finishes all started transactions before release, except when the host asserts back-off.
// - one idle cycle when mastership moves between processors.
// - the last master keeps requesting and regains the bus after the host.
// - tenure value all ones disables the tenure limit.
// - while locked ignore priority, host and tenure; yield only on back-off.
`timescale 1ns/10ps

module mba_arbiter
  import mba_pkg::*;
#(
  parameter int NPROC = MBA_NPROC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // identity pins, static except in reset
  input wire logic [MBA_ID_W-1:0] processor_id_pins,
  // shared request lines, active low, one per processor
  input wire logic [NPROC-1:0] proc_request_lines_in_n,
  output logic [NPROC-1:0] proc_request_lines_out_n,
  output logic [NPROC-1:0] proc_request_lines_oe,
  // wired priority-access lines, active low open drain
  input wire logic core_priority_access_in_n,
  output logic core_priority_access_out_n,
  output logic core_priority_access_oe,
  input wire logic dma_priority_access_in_n,
  output logic dma_priority_access_out_n,
  output logic dma_priority_access_oe,
  // host handshake, active low
  input wire logic host_request_n,
  input wire logic back_off_input_n,
  input wire logic host_grant_in_n,
  output logic host_grant_out_n,
  output logic host_grant_oe,
  // indicators, active low
  output logic master_indicator_n,
  output logic lock_indicator_n,
  // tenure limit in core clock cycles
  input wire logic [15:0] tenure_limit_count,
  // local external port
  input wire mba_local_req_t local_req,
  output mba_local_stat_t local_stat
);

  // -----------------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------------
  logic [NPROC-1:0] br_meta, br_sync;
  logic [3:0] ctl_meta, ctl_sync;
  logic [MBA_ID_W-1:0] id_meta, id_sync;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      br_meta <= '0;
      br_sync <= '0;
      ctl_meta <= 4'h0;
      ctl_sync <= 4'h0;
      id_meta <= MBA_RESET_MASTER;
      id_sync <= MBA_RESET_MASTER;
    end else begin
      br_meta <= ~proc_request_lines_in_n;
      br_sync <= br_meta;
      ctl_meta <= {~core_priority_access_in_n, ~dma_priority_access_in_n,
                   ~host_request_n, ~back_off_input_n};
      ctl_sync <= ctl_meta;
      id_meta <= processor_id_pins;
      id_sync <= id_meta;
    end
  end

  logic cpa_seen, dpa_seen, hbr_seen, back_off_input_seen;
  assign cpa_seen = ctl_sync[3];
  assign dpa_seen = ctl_sync[2];
  assign hbr_seen = ctl_sync[1];
  assign back_off_input_seen = ctl_sync[0];

  // -----------------------------------------------------------------------
  // identity capture
  // -----------------------------------------------------------------------
  // the id is reloaded for three cycles after reset release; later pin changes are ignored
  logic [MBA_ID_W-1:0] my_id;
  logic [1:0] id_settle;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      my_id <= MBA_RESET_MASTER;
      id_settle <= 2'h0;
    end else if (id_settle != 2'h3) begin
      id_settle <= id_settle + 2'h1;
      my_id <= id_sync;
    end
  end

  // -----------------------------------------------------------------------
  // shared arbitration state, identical in every processor
  // -----------------------------------------------------------------------
  mba_phase_t phase;
  logic [MBA_ID_W-1:0] master_id;
  logic [MBA_ID_W-1:0] next_master_id;
  logic [15:0] tenure;
  logic locked;
  logic handover;
  logic any_other;
  logic prio_other;
  logic expired;

  logic i_am_master;
  assign i_am_master = (master_id == my_id);

  // pick the winner: priority-access requesters first, then any requester,
  // scanning upward from the master so the old owner comes last
  logic [NPROC-1:0] cand;
  logic master_has_cpa, master_has_dpa;

  // own priority class is known locally; others are inferred from wired lines
  assign master_has_cpa = i_am_master && local_req.core_access;
  assign master_has_dpa = i_am_master && local_req.dma_access;

  always_comb begin
    // requesters not able to match the active priority class drop their line,
    // so the wired lines plus requests already give the class
    cand = br_sync;
    cand[master_id] = 1'b0;
    any_other = |cand;
    prio_other = any_other && ((cpa_seen && !master_has_cpa) ||
                 (dpa_seen && !master_has_cpa && !master_has_dpa));
    next_master_id = master_id;
    for (int k = NPROC - 1; k >= 1; k--) begin
      if (cand[MBA_ID_W'((int'(master_id) + k) % NPROC)]) begin
        next_master_id = MBA_ID_W'((int'(master_id) + k) % NPROC);
      end
    end
  end

  assign expired = (tenure_limit_count != MBA_TENURE_OFF) && (tenure == 16'h0);

  // the master's own request line is the shared view of whether it still wants
  logic master_req;
  assign master_req = br_sync[master_id];

  always_comb begin
    handover = 1'b0;
    if (locked) begin
      handover = back_off_input_seen && hbr_seen;
    end else if (!master_req) begin
      handover = any_other || hbr_seen;
    end else begin
      handover = hbr_seen || prio_other || (expired && any_other);
    end
  end

  // -----------------------------------------------------------------------
  // mastership sequencer
  // -----------------------------------------------------------------------
  // the master's own request line drops only once its transaction is done,
  // so waiting for that drop keeps transfers from overlapping
  logic release_ok;
  assign release_ok = !master_req || (back_off_input_seen && hbr_seen);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase <= MBA_PROC;
      master_id <= MBA_RESET_MASTER;
    end else begin
      unique case (phase)
        MBA_PROC: begin
          if (handover && release_ok) begin
            if (hbr_seen) begin
              phase <= MBA_HOST;
            end else if (any_other) begin
              phase <= MBA_IDLE;
              master_id <= next_master_id;
            end
          end
        end
        MBA_IDLE: begin
          phase <= MBA_PROC;
        end
        MBA_HOST: begin
          // old master keeps its line asserted and regains the bus
          if (!hbr_seen) begin
            phase <= MBA_PROC;
          end
        end
        default: begin
          phase <= MBA_PROC;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // tenure counter, paused while the host holds the bus
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tenure <= MBA_TENURE_RESET;
    end else if (phase == MBA_IDLE) begin
      tenure <= tenure_limit_count;
    end else if (phase == MBA_PROC) begin
      if (expired && !any_other) begin
        tenure <= tenure_limit_count;
      end else if (tenure != 16'h0 && tenure_limit_count != MBA_TENURE_OFF) begin
        tenure <= tenure - 16'h1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // bus lock, only taken by the owner
  // -----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      locked <= 1'b0;
    end else if (phase == MBA_PROC && i_am_master && local_req.lock) begin
      locked <= 1'b1;
    end else if (!local_req.lock || !i_am_master || phase != MBA_PROC) begin
      locked <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // pin drivers
  // -----------------------------------------------------------------------
  logic my_req;
  logic owner;
  logic host_phase_mine;

  assign owner = i_am_master && (phase == MBA_PROC);
  assign host_phase_mine = i_am_master && (phase == MBA_HOST);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      my_req <= 1'b0;
    end else begin
      // a requester outside the active priority class stands back
      my_req <= host_phase_mine || local_req.lock ||
                (local_req.want_bus && !(owner && !local_req.in_flight && handover)) &&
                (local_req.core_access || !cpa_seen || owner) &&
                (local_req.core_access || local_req.dma_access || !dpa_seen || owner);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPROC; g++) begin : g_br
      assign proc_request_lines_oe[g] = (my_id == MBA_ID_W'(g)) && my_req;
      assign proc_request_lines_out_n[g] = 1'b0;
    end
  endgenerate

  logic cpa_drive, dpa_drive, hbg_drive;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cpa_drive <= 1'b0;
      dpa_drive <= 1'b0;
      hbg_drive <= 1'b0;
    end else begin
      cpa_drive <= local_req.want_bus && local_req.core_access;
      dpa_drive <= local_req.want_bus && local_req.dma_access &&
                   !local_req.core_access;
      hbg_drive <= (phase == MBA_HOST) && hbr_seen && i_am_master;
    end
  end

  // slaves only monitor the grant line
  logic unused_grant;
  assign unused_grant = host_grant_in_n;

  assign core_priority_access_oe = cpa_drive;
  assign core_priority_access_out_n = 1'b0;
  assign dma_priority_access_oe = dpa_drive;
  assign dma_priority_access_out_n = 1'b0;
  assign host_grant_oe = i_am_master;
  assign host_grant_out_n = !hbg_drive;

  logic bm_q, lock_q;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bm_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      bm_q <= owner;
      lock_q <= locked && owner;
    end
  end

  assign master_indicator_n = !bm_q;
  assign lock_indicator_n = !lock_q;

  assign local_stat.owner = owner;
  assign local_stat.float_bus = !owner;
  assign local_stat.self_refresh = (phase == MBA_HOST);
  assign local_stat.idle_cycle = (phase == MBA_IDLE);

endmodule

/* include/mba_pkg.sv */
// package for the multiprocessor bus arbiter: constants and carriers
package mba_pkg;

  // ---------------------------------------------------------------------
  // sizes and reset values
  // ---------------------------------------------------------------------
  localparam int MBA_NPROC = 8;
  localparam int MBA_ID_W = 3;
  localparam logic [2:0] MBA_RESET_MASTER = 3'h0;
  localparam logic [15:0] MBA_TENURE_OFF = 16'hFFFF;
  localparam logic [15:0] MBA_TENURE_RESET = 16'hFFFF;
  // idle cycles on a processor-to-processor hand-over
  localparam logic [1:0] MBA_IDLE_CYCLES = 2'h1;

  // ---------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------
  // requests coming from this processor's own external port
  typedef struct packed {
    logic want_bus;     // any transaction pending
    logic core_access;  // pending access started by the core
    logic dma_access;   // pending access by a high-priority dma channel
    logic lock;         // bus lock requested
    logic in_flight;    // a transaction has begun on the bus
  } mba_local_req_t;

  // status returned to the external port
  typedef struct packed {
    logic owner;        // this processor owns and may drive the bus
    logic float_bus;    // address, data, strobes, memory controls to high-z
    logic self_refresh; // put attached sdram into self-refresh
    logic idle_cycle;   // hand-over idle cycle on the bus
  } mba_local_stat_t;

  typedef enum logic [1:0] {
    MBA_PROC = 2'b00,  // a processor owns the bus
    MBA_IDLE = 2'b01,  // hand-over idle cycle
    MBA_HOST = 2'b10   // the host owns the bus
  } mba_phase_t;

endpackage

/* test/mba_arbiter_test.sv */
// self-checking bench for the multiprocessor bus arbiter
`timescale 1ns/10ps
module mba_arbiter_test import mba_pkg::*;;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] other_want = 8'h00;
  logic host_want = 1'b0;
  logic back_off_input_want = 1'b0;
  logic cpa_want = 1'b0;
  logic [15:0] tenure_limit = 16'hFFFF;
  logic idle_seen = 1'b0;
  mba_local_req_t local_req = '0;
  mba_local_stat_t local_stat;
  int err_count = 0;
  int tests_run = 0;
  wire [7:0] other_low, proc_request_lines_out_n, proc_request_lines_oe;
  wire host_request_n, back_off_input_n, host_grant_out_n, host_grant_oe, cpa_low;
  wire core_priority_access_out_n, core_priority_access_oe, master_indicator_n;
  wire dma_priority_access_out_n, dma_priority_access_oe, lock_indicator_n;
  // ----------------------------------------------------------------
  // wired lines, pulled up when nobody drives them
  // ----------------------------------------------------------------
  wire [7:0] req_wire = ~((proc_request_lines_oe & ~proc_request_lines_out_n) | other_low);
  wire core_wire = ~((core_priority_access_oe & ~core_priority_access_out_n) | cpa_low);
  wire dma_wire = ~(dma_priority_access_oe & ~dma_priority_access_out_n);
  wire grant_wire = ~(host_grant_oe & ~host_grant_out_n);

  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (local_stat.idle_cycle === 1'b1) idle_seen = 1'b1;

  mba_partner u_partner (.clk_sys(clk_sys), .other_want(other_want), .host_want(host_want),
    .back_off_input_want(back_off_input_want), .cpa_want(cpa_want), .other_low(other_low),
    .host_request_n(host_request_n), .back_off_input_n(back_off_input_n), .cpa_low(cpa_low));

  mba_arbiter DUT (.clk_sys(clk_sys), .rst(rst), .processor_id_pins(3'h0),
    .proc_request_lines_in_n(req_wire), .proc_request_lines_out_n(proc_request_lines_out_n),
    .proc_request_lines_oe(proc_request_lines_oe), .core_priority_access_in_n(core_wire),
    .core_priority_access_out_n(core_priority_access_out_n),
    .core_priority_access_oe(core_priority_access_oe), .dma_priority_access_in_n(dma_wire),
    .dma_priority_access_out_n(dma_priority_access_out_n),
    .dma_priority_access_oe(dma_priority_access_oe), .host_request_n(host_request_n),
    .back_off_input_n(back_off_input_n), .host_grant_in_n(grant_wire),
    .host_grant_out_n(host_grant_out_n), .host_grant_oe(host_grant_oe),
    .master_indicator_n(master_indicator_n), .lock_indicator_n(lock_indicator_n),
    .tenure_limit_count(tenure_limit), .local_req(local_req), .local_stat(local_stat));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // which 0 watches the grant, which 1 the master indicator
  task automatic wait_for(input int which, input logic val);
    int i;
    for (i = 0; i < 40 && (which ? master_indicator_n : host_grant_out_n) !== val; i++) tick(1);
    if (i == 40) begin
      err_count++;
      wrap_up();
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_request();
    check("master", master_indicator_n, 1'b0);
    check("req oe", proc_request_lines_oe, 8'h00);
    @(posedge clk_sys);
    local_req.want_bus <= 1'b1;
    local_req.core_access <= 1'b1;
    tick(3);
    check("req oe", proc_request_lines_oe, 8'h01);
    check("core oe", core_priority_access_oe, 1'b1);
    check("dma oe", dma_priority_access_oe, 1'b0);
    @(posedge clk_sys);
    local_req.core_access <= 1'b0;
    local_req.dma_access <= 1'b1;
    tick(3);
    check("core oe", core_priority_access_oe, 1'b0);
    check("dma oe", dma_priority_access_oe, 1'b1);
    @(posedge clk_sys);
    local_req.dma_access <= 1'b0;
  endtask
  task automatic t_host();
    @(posedge clk_sys);
    host_want <= 1'b1;
    wait_for(0, 1'b0);
    check("float", local_stat.float_bus, 1'b1);
    check("refresh", local_stat.self_refresh, 1'b1);
    check("grant oe", host_grant_oe, 1'b1);
    tick(6);
    check("grant", host_grant_out_n, 1'b0);
    check("req oe", proc_request_lines_oe, 8'h01);
    @(posedge clk_sys);
    host_want <= 1'b0;
    wait_for(0, 1'b1);
    wait_for(1, 1'b0);
    check("float", local_stat.float_bus, 1'b0);
  endtask
  task automatic t_yield();
    @(posedge clk_sys);
    local_req.want_bus <= 1'b0;
    other_want <= 8'h08;
    idle_seen = 1'b0;
    wait_for(1, 1'b1);
    tick(2);
    check("idle", idle_seen, 1'b1);
    @(posedge clk_sys);
    local_req.want_bus <= 1'b1;
    tick(4);
    check("req oe", proc_request_lines_oe, 8'h01);
    check("master", master_indicator_n, 1'b1);
    @(posedge clk_sys);
    other_want <= 8'h00;
    wait_for(1, 1'b0);
  endtask
  task automatic t_lock();
    @(posedge clk_sys);
    local_req.lock <= 1'b1;
    tick(3);
    check("lock", lock_indicator_n, 1'b0);
    @(posedge clk_sys);
    host_want <= 1'b1;
    tick(10);
    check("grant", host_grant_out_n, 1'b1);
    check("master", master_indicator_n, 1'b0);
    @(posedge clk_sys);
    back_off_input_want <= 1'b1;
    wait_for(0, 1'b0);
    @(posedge clk_sys);
    host_want <= 1'b0;
    back_off_input_want <= 1'b0;
    local_req.lock <= 1'b0;
    wait_for(0, 1'b1);
    wait_for(1, 1'b0);
  endtask
  // tenure expiry, disabled tenure, then a core priority request from another processor
  task automatic t_tenure();
    @(posedge clk_sys);
    local_req.want_bus <= 1'b0;
    tenure_limit <= 16'h0010;
    other_want <= 8'h08;
    wait_for(1, 1'b1);
    @(posedge clk_sys);
    local_req.want_bus <= 1'b1;
    other_want <= 8'h00;
    wait_for(1, 1'b0);
    @(posedge clk_sys);
    other_want <= 8'h08;
    tick(5);
    check("master", master_indicator_n, 1'b0);
    wait_for(1, 1'b1);
    tick(2);
    check("req oe", proc_request_lines_oe, 8'h01);
    @(posedge clk_sys);
    other_want <= 8'h00;
    wait_for(1, 1'b0);
    @(posedge clk_sys);
    tenure_limit <= 16'hFFFF;
    other_want <= 8'h08;
    tick(30);
    check("master", master_indicator_n, 1'b0);
    @(posedge clk_sys);
    cpa_want <= 1'b1;
    wait_for(1, 1'b1);
    tick(2);
    check("req oe", proc_request_lines_oe, 8'h00);
    @(posedge clk_sys);
    cpa_want <= 1'b0;
    other_want <= 8'h00;
    wait_for(1, 1'b0);
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    tick(4);
    t_request();
    t_host();
    t_yield();
    t_lock();
    t_tenure();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    wrap_up();
  end
endmodule

bind mba_arbiter mba_monitor #(.NPROC(NPROC)) u_monitor (.clk_sys(clk_sys), .rst(rst),
  .processor_id_pins(processor_id_pins), .proc_request_lines_oe(proc_request_lines_oe),
  .core_priority_access_oe(core_priority_access_oe),
  .dma_priority_access_oe(dma_priority_access_oe),
  .core_priority_access_in_n(core_priority_access_in_n),
  .dma_priority_access_in_n(dma_priority_access_in_n), .host_request_n(host_request_n),
  .back_off_input_n(back_off_input_n), .host_grant_out_n(host_grant_out_n),
  .master_indicator_n(master_indicator_n), .lock_indicator_n(lock_indicator_n),
  .local_req(local_req), .local_stat(local_stat));

/* test/mba_monitor.sv */
// port-level assertions for the multiprocessor bus arbiter
`timescale 1ns/10ps
module mba_monitor
  import mba_pkg::*;
#(
  parameter int NPROC = MBA_NPROC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // arbitration pins
  input wire logic [MBA_ID_W-1:0] processor_id_pins,
  input wire logic [NPROC-1:0] proc_request_lines_oe,
  input wire logic core_priority_access_oe,
  input wire logic dma_priority_access_oe,
  input wire logic core_priority_access_in_n,
  input wire logic dma_priority_access_in_n,
  input wire logic host_request_n,
  input wire logic back_off_input_n,
  input wire logic host_grant_out_n,
  input wire logic master_indicator_n,
  input wire logic lock_indicator_n,
  // local port
  input wire mba_local_req_t local_req,
  input wire mba_local_stat_t local_stat
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  one_line_a: assert property ((proc_request_lines_oe & ~(NPROC'(1) << processor_id_pins)) == '0)
    else $error("request driven on a foreign line");
  // a non-owner seeking the bus drives its line unless a priority line was sensed
  req_oe_a: assert property (master_indicator_n && $past(local_req.want_bus)
    && $past(core_priority_access_in_n, 3) && $past(dma_priority_access_in_n, 3)
    |-> proc_request_lines_oe[processor_id_pins]) else $error("request line not driven");
  held_req_a: assert property (!host_grant_out_n |-> proc_request_lines_oe[processor_id_pins])
    else $error("request dropped during host grant");
  core_oe_a: assert property ((local_req.want_bus && local_req.core_access) [*2]
    |-> core_priority_access_oe) else $error("core priority line not driven");
  dma_oe_a: assert property ((local_req.want_bus && local_req.dma_access
    && !local_req.core_access) [*2] |-> dma_priority_access_oe) else $error("dma line not driven");
  lock_own_a: assert property (!lock_indicator_n |-> !master_indicator_n)
    else $error("lock shown without ownership");
  lock_hold_a: assert property (!lock_indicator_n && local_req.lock && $past(local_req.lock)
    && back_off_input_n && $past(back_off_input_n) && $past(back_off_input_n, 2)
    |=> !master_indicator_n) else $error("locked bus given up");
  grant_cause_a: assert property ($fell(host_grant_out_n) |-> !$past(host_request_n, 2))
    else $error("grant without host request");
  grant_hold_a: assert property (!host_grant_out_n && !host_request_n |=> !host_grant_out_n)
    else $error("grant dropped while host requests");
  float_bus_a: assert property ($fell(host_grant_out_n)
    |-> local_stat.float_bus && local_stat.self_refresh) else $error("bus not floated for host");
  idle_once_a: assert property (local_stat.idle_cycle |=> !local_stat.idle_cycle)
    else $error("idle cycle too long");

  cover property ($fell(host_grant_out_n));
  cover property ($rose(master_indicator_n));
  cover property ($fell(lock_indicator_n));
endmodule

/* test/mba_partner.sv */
// behavioural model of the other processors and the host
`timescale 1ns/10ps
module mba_partner (
  // clock
  input wire logic clk_sys,
  // commands from the bench
  input wire logic [7:0] other_want,
  input wire logic host_want,
  input wire logic back_off_input_want,
  input wire logic cpa_want,
  // levels put on the shared lines
  output logic [7:0] other_low,
  output logic host_request_n,
  output logic back_off_input_n,
  output logic cpa_low
);
  initial begin
    other_low = 8'h00;
    cpa_low = 1'b0;
    host_request_n = 1'b1;
    back_off_input_n = 1'b1;
  end
  // line 0 belongs to the device, so no one else pulls it
  always @(posedge clk_sys) other_low <= other_want & 8'hFE;
  always @(posedge clk_sys) host_request_n <= ~host_want;
  // another processor pulling the wired core priority line
  always @(posedge clk_sys) cpa_low <= cpa_want;
  // back-off is only meaningful while the host is requesting
  always @(posedge clk_sys) back_off_input_n <= ~(back_off_input_want & host_want);
endmodule
